// File: rtl/link_pkg.sv
// Purpose: shared constants for the lighting link unit
// Assumes: core clock 25 MHz, prescaler programmed by software
// Notes: sample counts are in prescaled sample ticks, not core cycles
package link_pkg;

	// ----------------------------------------
	// clocking and sampling
	// ----------------------------------------
	localparam int CORE_CLK_HZ = 25000000;
	localparam int NOMINAL_LINK_HZ = 1200;
	localparam int PRESCALE_W_DEF = 8;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;
	localparam logic [3:0] PHASE_SAMPLES_LAST = 4'hF;
	localparam logic [3:0] MAJ_SAMPLE_A = 4'h6;
	localparam logic [3:0] MAJ_SAMPLE_B = 4'h7;
	localparam logic [3:0] MAJ_SAMPLE_C = 4'h8;
	localparam logic [3:0] PRESHIFT_SAMPLE = 4'h9;
	localparam logic [3:0] PRESHIFT_RESET = 4'hF;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int SHIFT_W = 16;
	localparam logic [4:0] FWD_DATA_BITS = 5'h10;
	localparam logic [4:0] FWD_STOP_LAST = 5'h11;
	localparam logic [4:0] TX_PHASES_LAST = 5'h15;
	localparam logic [4:0] TX_FIRST_SHIFT = 5'h03;
	localparam logic [4:0] TX_STOP_PHASE = 5'h12;
	localparam logic [1:0] PAIR_ONE = 2'h1;
	localparam logic [1:0] PAIR_ZERO = 2'h2;
	localparam logic [1:0] PAIR_IDLE = 2'h3;

	// ----------------------------------------
	// bus failure: two bit periods = four phases
	// ----------------------------------------
	localparam logic [6:0] FAIL_SAMPLES = 7'h40;

	// ----------------------------------------
	// reset values and buffering
	// ----------------------------------------
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam int FIFO_DEPTH_DEF = 16;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_PUSH,
		ST_DONE,
		ST_TX
	} link_state_t;

endpackage : link_pkg

// File: rtl/link_rate_divider.sv
// Purpose: sample tick generator, one tick every (prescaler+1) core cycles
// Assumes: prescaler value stable while the link is busy
// Notes: sixteen ticks make one bit phase
`timescale 1ns/1ps
module link_rate_divider #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// control
	input wire logic run_i,
	input wire logic restart_i,
	input wire logic [WIDTH-1:0] divide_i,
	// tick
	output logic tick_o
);

	logic [WIDTH-1:0] count;
	wire at_end = (count == divide_i);

	assign tick_o = run_i & at_end & ~restart_i;

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || restart_i) begin
			count <= '0;
		end else if (run_i) begin
			count <= at_end ? '0 : count + 1'b1;
		end
	end

endmodule : link_rate_divider

// File: rtl/link_word_fifo.sv
// Purpose: word FIFO between frame receiver and software side
// Assumes: single clock, synchronous active-low reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module link_word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire do_push = in_valid_i & ~full;
	wire do_pop = out_ready_i & ~empty;

	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge core_clk_i) begin
		if (do_push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule : link_word_fifo

// File: rtl/lighting_link_unit.sv
// Purpose: bi-phase lighting link receiver/transmitter for a ballast
// Assumes: control bits arrive as plain ports, acknowledge and reads as pulses
// Notes: received frames also queue in a word FIFO for the software side
//
// Operation
// - sample tick is core clock over (prescaler+1)
// - start bit is always a logical one
// - two high stop bits end each frame
// - format error discards frame, back to receive
// - after reset wait for forward start bit
// - forward frame shifted MSB first, bytes loaded
// - good forward frame sets frame done
// - backward byte shifted out MSB first
// - finished backward frame sets frame done
// - nothing new starts until acknowledge
// - pre-shifter samples input in every state
// - force transmit sends backward byte, flags done
// - enable change resets the whole state machine
// - input low two bits in receive flags error
// - status read clears error flag
// - halt freezes registers except low_cnt and divider count, cleared by enable change; other modes no effect
// - majority of samples six to eight, shift at nine
// - only second phase enters data shifter
// - edge copies sample count out, then clears it
// - forward frame: start, address, data, two stops
// - backward frame: start, data, two stops
// - frame done interrupts only when enabled
// - acknowledge clears frame done, self-clearing
`timescale 1ns/1ps
module lighting_link_unit import link_pkg::*; #(
	parameter int PRESCALE_W = PRESCALE_W_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic halt_i,
	// configuration and control
	input wire logic [PRESCALE_W-1:0] rate_prescaler_i,
	input wire logic unit_enable_i,
	input wire logic transmit_select_i,
	input wire logic force_transmit_i,
	input wire logic frame_acknowledge_i,
	input wire logic frame_irq_enable_i,
	input wire logic status_read_i,
	// backward data
	input wire logic backward_write_i,
	input wire logic [7:0] backward_data_i,
	// link pins
	input wire logic link_input_i,
	output logic link_output_o,
	// status
	output logic [7:0] forward_address_o,
	output logic [7:0] forward_data_o,
	output logic frame_done_flag_o,
	output logic format_error_flag_o,
	output logic receive_state_o,
	output logic [3:0] sample_count_o,
	output logic irq_o,
	// forward frame queue
	output logic fwd_valid_o,
	input wire logic fwd_ready_i,
	output logic [SHIFT_W-1:0] fwd_word_o
);

	// ----------------------------------------
	// state and registers
	// ----------------------------------------
	link_state_t state, next_state;
	logic enable_q, last_samp, maj_a, maj_b, phase_lvl, half, last_tx;
	logic frame_done, error_flag, link_out, fifo_in_ready, tick;
	logic [3:0] samp_cnt, status_cnt, preshift, tx_cnt;
	logic [4:0] bit_cnt, tx_phase;
	logic [6:0] low_cnt;
	logic [SHIFT_W-1:0] shreg;
	logic [7:0] forward_address_reg, forward_data_reg, backward_data_reg;

	// ----------------------------------------
	// global qualifiers
	// ----------------------------------------
	// halt freezes everything but low_cnt and the divider count, which a disable or enable change clears; wait modes need no input at all
	wire run = ~halt_i;
	wire en_toggle = unit_enable_i != enable_q;
	wire fsm_clear = en_toggle | ~unit_enable_i;
	wire active = run & unit_enable_i;
	wire tick_en = tick & active;

	link_rate_divider #(
		.WIDTH(PRESCALE_W)
	) u_divider (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.run_i(active),
		.restart_i(en_toggle),
		.divide_i(rate_prescaler_i),
		.tick_o(tick)
	);

	// ----------------------------------------
	// sampling and pre-shifter
	// ----------------------------------------
	wire edge_seen = tick_en & (link_input_i != last_samp);
	wire maj_now = (maj_a & maj_b) | (maj_a & link_input_i) | (maj_b & link_input_i);
	wire phase_tick = tick_en & (samp_cnt == PRESHIFT_SAMPLE);
	wire [1:0] pair = preshift[1:0];
	wire pair_ok = (pair == PAIR_ONE) | (pair == PAIR_ZERO);

	// the counter only wraps mod 16, so a long steady level keeps producing phases
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			last_samp <= 1'b1;
			samp_cnt <= COUNT_RESET;
			status_cnt <= COUNT_RESET;
		end else if (tick_en) begin
			last_samp <= link_input_i;
			if (edge_seen) begin
				status_cnt <= samp_cnt;
				samp_cnt <= COUNT_RESET;
			end else begin
				samp_cnt <= samp_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			maj_a <= 1'b1;
			maj_b <= 1'b1;
			phase_lvl <= 1'b1;
			preshift <= PRESHIFT_RESET;
		end else if (tick_en) begin
			if (samp_cnt == MAJ_SAMPLE_A) begin
				maj_a <= link_input_i;
			end
			if (samp_cnt == MAJ_SAMPLE_B) begin
				maj_b <= link_input_i;
			end
			if (samp_cnt == MAJ_SAMPLE_C) begin
				phase_lvl <= maj_now;
			end
			if (samp_cnt == PRESHIFT_SAMPLE) begin
				preshift <= {preshift[2:0], phase_lvl};
			end
		end
	end
	wire in_receive = (state == ST_IDLE) | (state == ST_RX);
	wire fail_hit = tick_en & in_receive & ~link_input_i & (low_cnt == FAIL_SAMPLES - 7'h01);

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || fsm_clear) begin
			low_cnt <= 7'h00;
		end else if (tick_en) begin
			if (!in_receive || link_input_i) begin
				low_cnt <= 7'h00;
			end else if (low_cnt != FAIL_SAMPLES) begin
				low_cnt <= low_cnt + 7'h01;
			end
		end
	end

	// ----------------------------------------
	// frame control decode
	// ----------------------------------------
	wire start_seen = (state == ST_IDLE) & phase_tick & (pair == PAIR_ONE);
	wire rx_bit_end = (state == ST_RX) & phase_tick & half;
	wire in_data = bit_cnt < FWD_DATA_BITS;
	wire rx_bad = rx_bit_end & (in_data ? ~pair_ok : (pair != PAIR_IDLE));
	wire rx_shift = rx_bit_end & in_data & pair_ok;
	wire rx_stop_end = rx_bit_end & (bit_cnt == FWD_STOP_LAST) & (pair == PAIR_IDLE);
	wire push_ok = (state == ST_PUSH) & fifo_in_ready & run;
	wire ack_go = (state == ST_DONE) & frame_acknowledge_i;
	// a transmit_select_i request right after a backward frame is turned into receive; force transmit still sends
	wire tx_req = force_transmit_i | (transmit_select_i & ~last_tx);
	wire tx_step = (state == ST_TX) & tick_en & (tx_cnt == PHASE_SAMPLES_LAST);
	wire tx_end = tx_step & (tx_phase == TX_PHASES_LAST);
	wire tx_enter = (next_state == ST_TX) & (state != ST_TX);
	wire tx_shift = tx_step & tx_phase[0] & (tx_phase >= TX_FIRST_SHIFT) & (tx_phase < TX_STOP_PHASE);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (force_transmit_i) begin
					next_state = ST_TX;
				end else if (start_seen) begin
					next_state = ST_RX;
				end
			end
			ST_RX: begin
				if (rx_bad) begin
					next_state = ST_IDLE;
				end else if (rx_stop_end) begin
					next_state = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (push_ok) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (ack_go) begin
					next_state = tx_req ? ST_TX : ST_IDLE;
				end
			end
			ST_TX: begin
				if (tx_end) begin
					next_state = ST_DONE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (fsm_clear) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state <= ST_IDLE;
			enable_q <= 1'b0;
		end else if (run) begin
			state <= next_state;
			enable_q <= unit_enable_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i || (run && fsm_clear)) begin
			half <= 1'b0;
			bit_cnt <= 5'h00;
		end else if (run) begin
			if (start_seen) begin
				half <= 1'b0;
				bit_cnt <= 5'h00;
			end else if ((state == ST_RX) && phase_tick) begin
				half <= ~half;
				if (half) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			shreg <= '0;
		end else if (run) begin
			if (tx_enter) begin
				shreg <= {backward_data_reg, BYTE_RESET};
			end else if (rx_shift) begin
				shreg <= {shreg[SHIFT_W-2:0], pair[0]};
			end else if (tx_shift) begin
				shreg <= {shreg[SHIFT_W-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// transmit sequencing
	// ----------------------------------------
	// phases 0-1 start bit, 2-17 data, 18-21 stop bits held high
	wire tx_bit = (tx_phase[4:1] == 4'h0) ? 1'b1 : shreg[SHIFT_W-1];
	wire tx_level = (tx_phase >= TX_STOP_PHASE) ? 1'b1 : (tx_phase[0] ? tx_bit : ~tx_bit);

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			tx_cnt <= COUNT_RESET;
			tx_phase <= 5'h00;
			link_out <= 1'b1;
		end else if (run) begin
			link_out <= ((state == ST_TX) && !fsm_clear) ? tx_level : 1'b1;
			if (tx_enter) begin
				tx_cnt <= COUNT_RESET;
				tx_phase <= 5'h00;
			end else if ((state == ST_TX) && tick_en) begin
				tx_cnt <= tx_cnt + 4'h1;
				if (tx_step) begin
					tx_phase <= tx_phase + 5'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			frame_done <= 1'b0;
			last_tx <= 1'b0;
		end else if (run) begin
			if (fsm_clear) begin
				frame_done <= 1'b0;
				last_tx <= 1'b0;
			end else if (push_ok || tx_end) begin
				frame_done <= 1'b1;
				last_tx <= tx_end;
			end else if (ack_go) begin
				frame_done <= 1'b0;
			end
		end
	end

	// set wins over a clearing read in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			error_flag <= 1'b0;
		end else if (run) begin
			if (rx_bad || fail_hit) begin
				error_flag <= 1'b1;
			end else if (status_read_i) begin
				error_flag <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			forward_address_reg <= BYTE_RESET;
			forward_data_reg <= BYTE_RESET;
			backward_data_reg <= BYTE_RESET;
		end else if (run) begin
			if (push_ok) begin
				forward_address_reg <= shreg[15:8];
				forward_data_reg <= shreg[7:0];
			end
			if (backward_write_i) begin
				backward_data_reg <= backward_data_i;
			end
		end
	end

	// a full queue holds the frame in push, which stalls further reception
	link_word_fifo #(
		.WIDTH(SHIFT_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i((state == ST_PUSH) & run),
		.in_ready_o(fifo_in_ready),
		.in_data_i(shreg),
		.out_valid_o(fwd_valid_o),
		.out_ready_i(fwd_ready_i & run),
		.out_data_o(fwd_word_o)
	);
	assign link_output_o = link_out;
	assign forward_address_o = forward_address_reg;
	assign forward_data_o = forward_data_reg;
	assign frame_done_flag_o = frame_done;
	assign format_error_flag_o = error_flag;
	assign receive_state_o = (state != ST_TX);
	assign sample_count_o = status_cnt;
	assign irq_o = frame_done & frame_irq_enable_i;

endmodule : lighting_link_unit

// File: verif/lighting_link_unit_chk.sv
// Purpose: port-level assertions for the lighting link unit
// Assumes: one clock, synchronous active-low reset
// Notes: enable changes are tracked locally
`timescale 1ns/1ps
module lighting_link_unit_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// control
	input wire logic halt_i,
	input wire logic unit_enable_i,
	input wire logic force_transmit_i,
	input wire logic frame_acknowledge_i,
	input wire logic frame_irq_enable_i,
	input wire logic status_read_i,
	// status
	input wire logic link_output_o,
	input wire logic [7:0] forward_address_o,
	input wire logic [7:0] forward_data_o,
	input wire logic frame_done_flag_o,
	input wire logic format_error_flag_o,
	input wire logic receive_state_o,
	input wire logic irq_o
);
	// --------------------
	// properties
	// --------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	logic en_q;
	logic en_chg;
	assign en_chg = unit_enable_i != en_q;
	always_ff @(posedge core_clk_i) begin
		en_q <= reset_n_i & unit_enable_i;
	end
	property p_irq; irq_o == (frame_done_flag_o && frame_irq_enable_i); endproperty
	a_irq: assert property (p_irq) else $error("irq differs from flag and enable");
	property p_ack; frame_acknowledge_i && frame_done_flag_o && !halt_i && !en_chg |=> !frame_done_flag_o; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge left done flag set");
	property p_hold; frame_done_flag_o && !frame_acknowledge_i && !en_chg |=> frame_done_flag_o && $stable(forward_data_o); endproperty
	a_hold: assert property (p_hold) else $error("done state left without acknowledge");
	property p_load; $changed(forward_address_o) || $changed(forward_data_o) |-> $rose(frame_done_flag_o) || $past(en_chg); endproperty
	a_load: assert property (p_load) else $error("forward bytes changed without frame done");
	property p_idle; receive_state_o |-> link_output_o; endproperty
	a_idle: assert property (p_idle) else $error("output low outside transmit");
	property p_halt; halt_i |=> $stable(link_output_o) && $stable(forward_address_o) && $stable(frame_done_flag_o); endproperty
	a_halt: assert property (p_halt) else $error("registers moved in halt");
	property p_err; $fell(format_error_flag_o) |-> $past(status_read_i || en_chg); endproperty
	a_err: assert property (p_err) else $error("error flag cleared without status read");
	property p_en; en_chg && !halt_i |=> receive_state_o; endproperty
	a_en: assert property (p_en) else $error("enable change did not reset to receive");
	property p_force; frame_acknowledge_i && frame_done_flag_o && force_transmit_i && unit_enable_i && !halt_i && !en_chg
		|=> !receive_state_o ##[1:4] !link_output_o; endproperty
	a_force: assert property (p_force) else $error("forced acknowledge did not start a frame");
endmodule : lighting_link_unit_chk
bind lighting_link_unit lighting_link_unit_chk lighting_link_unit_chk_i (.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i), .halt_i(halt_i), .unit_enable_i(unit_enable_i), .force_transmit_i(force_transmit_i),
	.frame_acknowledge_i(frame_acknowledge_i), .frame_irq_enable_i(frame_irq_enable_i),
	.status_read_i(status_read_i), .link_output_o(link_output_o), .forward_address_o(forward_address_o),
	.forward_data_o(forward_data_o), .frame_done_flag_o(frame_done_flag_o),
	.format_error_flag_o(format_error_flag_o), .receive_state_o(receive_state_o), .irq_o(irq_o));

// File: verif/link_master_model.sv
// Purpose: network master on the far side of the link
// Assumes: line idles high, phase length given in core cycles
// Notes: backward frames are kept as mid-phase samples
`timescale 1ns/1ps
module link_master_model (
	// clock
	input wire logic core_clk_i,
	// link lines
	input wire logic dev_line_i,
	output logic bus_line_o,
	// timing
	input wire logic [15:0] phase_clks_i
);
	// --------------------
	// line driver and sampler
	// --------------------
	logic [21:0] back_phases;
	logic [21:0] shift;
	initial bus_line_o = 1'b1;
	task automatic hold(input logic v, input int n);
		bus_line_o = v;
		repeat (n * phase_clks_i) @(negedge core_clk_i);
	endtask : hold
	// bad_at names a data bit whose second phase repeats the first
	task automatic send_frame(input logic [15:0] word, input int bad_at);
		hold(1'b0, 1);
		hold(1'b1, 1);
		for (int i = 15; i >= 0; i--) begin
			hold(!word[i], 1);
			hold(i == bad_at ? !word[i] : word[i], 1);
		end
		hold(1'b1, 4);
	endtask : send_frame
	initial begin
		back_phases = 22'h0;
		forever begin
			@(negedge dev_line_i);
			repeat (phase_clks_i / 2) @(negedge core_clk_i);
			for (int p = 0; p < 22; p++) begin
				shift = {shift[20:0], dev_line_i};
				if (p < 21) repeat (phase_clks_i) @(negedge core_clk_i);
			end
			back_phases = shift;
		end
	end
endmodule : link_master_model

// File: verif/lighting_link_unit_tb.sv
// Purpose: self-checking bench for the lighting link unit
// Assumes: partner model drives the line, prescaler kept small
// Notes: the queue is filled to refusal before draining
`timescale 1ns/1ps
module lighting_link_unit_tb;
	// --------------------
	// signals and instances
	// --------------------
	logic core_clk_i, reset_n_i, halt_i, unit_enable_i, transmit_select_i, force_transmit_i, fwd_ready_i;
	logic frame_acknowledge_i, frame_irq_enable_i, status_read_i, backward_write_i, link_input_i, link_output_o;
	logic frame_done_flag_o, format_error_flag_o, receive_state_o, irq_o, fwd_valid_o;
	logic [7:0] rate_prescaler_i, backward_data_i, forward_address_o, forward_data_o, b;
	logic [3:0] sample_count_o;
	logic [15:0] fwd_word_o, w, phase_clks;
	logic [15:0] q[$];
	int n_errors, n_compared;
	assign phase_clks = {4'h0, rate_prescaler_i + 8'h01, 4'h0};
	lighting_link_unit lighting_link_unit_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .halt_i(halt_i),
		.rate_prescaler_i(rate_prescaler_i), .unit_enable_i(unit_enable_i), .transmit_select_i(transmit_select_i),
		.force_transmit_i(force_transmit_i), .frame_acknowledge_i(frame_acknowledge_i),
		.frame_irq_enable_i(frame_irq_enable_i), .status_read_i(status_read_i), .backward_write_i(backward_write_i),
		.backward_data_i(backward_data_i), .link_input_i(link_input_i), .link_output_o(link_output_o),
		.forward_address_o(forward_address_o), .forward_data_o(forward_data_o), .frame_done_flag_o(frame_done_flag_o),
		.format_error_flag_o(format_error_flag_o), .receive_state_o(receive_state_o),
		.sample_count_o(sample_count_o), .irq_o(irq_o), .fwd_valid_o(fwd_valid_o), .fwd_ready_i(fwd_ready_i),
		.fwd_word_o(fwd_word_o));
	link_master_model link_master_model_i (.core_clk_i(core_clk_i), .dev_line_i(link_output_o),
		.bus_line_o(link_input_i), .phase_clks_i(phase_clks));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	task report_and_stop;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task check_val(input logic [21:0] got, input logic [21:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : check_val
	task wait_done;
		for (int k = 0; frame_done_flag_o !== 1'b1; k++) begin
			if (k == 4000) begin
				n_errors++;
				report_and_stop;
			end
			@(negedge core_clk_i);
		end
	endtask : wait_done
	task ack(input logic sel);
		transmit_select_i = sel;
		frame_acknowledge_i = 1'b1;
		@(negedge core_clk_i);
		frame_acknowledge_i = 1'b0;
	endtask : ack
	task write_back(input logic [7:0] v);
		backward_data_i = v;
		backward_write_i = 1'b1;
		@(negedge core_clk_i);
		backward_write_i = 1'b0;
	endtask : write_back
	task read_status;
		status_read_i = 1'b1;
		@(negedge core_clk_i);
		status_read_i = 1'b0;
		check_val(format_error_flag_o, 1'b0);
	endtask : read_status
	// phases of a backward frame: start one, eight data bits, four high
	function automatic logic [21:0] exp_back(input logic [7:0] v);
		logic [21:0] f;
		f = 22'h1;
		for (int i = 7; i >= 0; i--) f = {f[19:0], !v[i], v[i]};
		return {f[17:0], 4'hF};
	endfunction : exp_back
	task expect_back(input logic [7:0] v);
		wait_done;
		check_val(link_master_model_i.back_phases, exp_back(v));
		link_master_model_i.back_phases = 22'h0;
	endtask : expect_back
	// --------------------
	// main sequence
	// --------------------
	initial begin
		{reset_n_i, halt_i, unit_enable_i, transmit_select_i, force_transmit_i, fwd_ready_i} = 6'h00;
		{frame_acknowledge_i, frame_irq_enable_i, status_read_i, backward_write_i} = 4'h0;
		{rate_prescaler_i, backward_data_i} = 16'h0100;
		n_errors = 0;
		n_compared = 0;
		void'($urandom(25));
		repeat (2) @(negedge core_clk_i);
		check_val({forward_address_o, forward_data_o, link_output_o, frame_done_flag_o, format_error_flag_o,
			receive_state_o, fwd_valid_o, irq_o}, 22'h000024);
		reset_n_i = 1'b1;
		unit_enable_i = 1'b1;
		@(negedge core_clk_i);
		for (int i = 0; i < 17; i++) begin
			w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			frame_irq_enable_i = i[0];
			q.push_back(w);
			link_master_model_i.send_frame(w, -1);
			if (i < 16) begin
				wait_done;
				check_val({forward_address_o, forward_data_o}, w);
				check_val(irq_o, i[0]);
				// edges of a clean frame lie one or two full phases apart: last sample index 15
				check_val(sample_count_o, 4'hF);
				if (i == 0) begin
					link_master_model_i.send_frame(16'hA55A, -1);
					check_val({frame_done_flag_o, forward_data_o}, 9'h100);
				end
				ack(1'b0);
			end
		end
		// give the last frame time to reach the push stage before draining
		repeat (100) @(negedge core_clk_i);
		check_val(frame_done_flag_o, 1'b0); // full queue stalls the frame
		fwd_ready_i = 1'b1;
		foreach (q[j]) begin
			check_val({fwd_valid_o, fwd_word_o}, {1'b1, q[j]});
			@(negedge core_clk_i);
		end
		check_val(fwd_valid_o, 1'b0);
		wait_done;
		check_val({forward_address_o, forward_data_o}, w);
		ack(1'b0);
		link_master_model_i.send_frame(w ^ 16'h0F0F, -1);
		wait_done;
		b = 8'($urandom);
		write_back(b);
		ack(1'b1);
		expect_back(b);
		ack(1'b1);
		repeat (10) @(negedge core_clk_i);
		check_val(receive_state_o, 1'b1);
		link_master_model_i.send_frame(16'h1234, 0);
		check_val({frame_done_flag_o, format_error_flag_o, forward_data_o}, {2'b01, ~w[7:0] ^ 8'hF0});
		read_status;
		link_master_model_i.hold(1'b0, 5);
		check_val({frame_done_flag_o, format_error_flag_o}, 2'b01);
		read_status;
		// release looks like a start bit and then fails the format check
		link_master_model_i.hold(1'b1, 4);
		check_val({frame_done_flag_o, format_error_flag_o}, 2'b01);
		read_status;
		unit_enable_i = 1'b0;
		rate_prescaler_i = 8'h02;
		@(negedge core_clk_i);
		write_back(b);
		{unit_enable_i, force_transmit_i} = 2'b11;
		expect_back(b);
		write_back(~b);
		ack(1'b0);
		repeat (200) @(negedge core_clk_i);
		halt_i = 1'b1;
		repeat (8) @(negedge core_clk_i);
		halt_i = 1'b0;
		expect_back(~b);
		{unit_enable_i, force_transmit_i} = 2'b00;
		@(negedge core_clk_i);
		unit_enable_i = 1'b1;
		@(negedge core_clk_i);
		check_val({receive_state_o, frame_done_flag_o}, 2'b10);
		report_and_stop;
	end
endmodule : lighting_link_unit_tb
